/* mbi_device.sv */
// device end: companion chip side of the host bus port
`timescale 1ns/100ps
`default_nettype none
module mbi_device (
   input  wire logic                   mclk,             // system clock
   input  wire logic                   rst_b,            // async reset, active low
   mbi_bus_if.dev                      bus,              // host bus pins
   input  wire logic                   mux_mode,         // 1: multiplexed bus
   input  wire logic                   burst_mode,       // 1: low port f carries a3..a1
   input  wire mbi_pkg::mbi_bus_type_t bus_type,         // control pin roles
   input  wire logic                   addr_out_en,      // show latched address
   input  wire logic [3:0]             ext_addr,         // upper address via ports a/b/c
   input  wire logic [3:0]             ext_match,        // upper address of this device
   output logic [15:0]                 latched_addr_out, // address for external parts
   output logic                        gla_in2,          // general_logic_array input
   output logic                        spare_pd3,        // aux pin free for other i/o
   output logic [3:0]                  spare_pf          // low port f free for other i/o
);

   // all device state: latch, store, drive values and freed pins
   mbi_pkg::mbi_dev_st_t st_reg;
   mbi_pkg::mbi_dev_st_t st_next;

   logic        ale;
   logic [3:0]  ctl;
   logic        rd;
   logic        wr;
   logic        ev;
   logic        od;
   logic        swap;
   logic [15:0] a;
   logic        hit;
   logic [3:0]  idx;
   logic [15:0] bus_d;
   logic [7:0]  even_b;
   logic [7:0]  odd_b;
   logic [15:0] word_q;
   logic [15:0] rbus;
   logic [15:0] lane_d;

   // byte swap shared by the write lane view and the read path
   function automatic logic [15:0] swap_bytes(input logic [15:0] d);
      swap_bytes = {d[7:0], d[15:8]};
   endfunction

   // limitation: a host on another clock would need pin synchronisers here;
   // the shared clock saves their cycles of read latency
   // both ends share mclk, so pins are used without synchronisers
   assign ale = bus.aux_latch_strobe_pin;
   assign ctl = {bus.aux_upper_write_pin, bus.control_input_two,
                 bus.control_input_one, bus.control_input_zero};

   // the strobe-high cycle decodes from the live pins, so a decode never
   // waits a cycle for the latch to fill
   // access address: live pins while the strobe is high or the bus is non-multiplexed, else the latch
   always_comb begin
      if (mux_mode) begin
         a = ale ? bus.shared_addr_data_port : st_reg.addr;
         if (burst_mode) begin
            // host steps only the lowest word lines during a burst
            a[3:1] = bus.low_port_f_address_pins[3:1];
         end
      end else begin
         // no latch strobe needed: the address stays on the pins
         a = bus.shared_addr_data_port;
      end
   end

   // a foreign upper address must neither drive nor store, or two parts
   // would fight on the shared wires
   // own resource window, upper lines from the extra ports
   assign hit = a[15:5] == mbi_pkg::RES_BASE && ext_addr == ext_match;
   assign idx = a[4:1];

   // roles are static config; changing bus_type mid-transfer is not supported
   // pin roles and byte lanes per bus type; ev/od are even/odd byte selects
   always_comb begin
      // defaults: nothing active unless the bus type decodes it
      rd   = 1'h0;
      wr   = 1'h0;
      ev   = 1'h0;
      od   = 1'h0;
      swap = 1'h0;
      case (bus_type)
         mbi_pkg::BT_WR_RD_BHE: begin
            wr = ~ctl[0];
            rd = ~ctl[1];
            ev = ~a[0];
            od = ~ctl[2];
         end
         mbi_pkg::BT_WRL_RD_WRH: begin
            rd = ~ctl[1];
            wr = ~ctl[0] | ~ctl[3];
            // reads fetch the whole word, writes follow each strobe
            ev = rd | ~ctl[0];
            od = rd | ~ctl[3];
         end
         mbi_pkg::BT_RW_DS_SIZ: begin
            rd   = ~ctl[1] & ctl[0];
            wr   = ~ctl[1] & ~ctl[0];
            ev   = ~a[0];
            od   = ~ctl[2] | a[0];
            swap = 1'h1;
         end
         mbi_pkg::BT_RW_LDS_UDS: begin
            rd   = (~ctl[1] | ~ctl[2]) & ctl[0];
            wr   = (~ctl[1] | ~ctl[2]) & ~ctl[0];
            ev   = ~ctl[2];
            od   = ~ctl[1];
            swap = 1'h1;
         end
         default: begin
            // unknown type: no access decoded, all lanes idle
            swap = 1'h0;
         end
      endcase
   end

   // the two host families disagree on which lane holds the even byte
   // lane unpacking: select/strobe hosts put the even byte on d15-d8
   assign bus_d  = mux_mode ? bus.shared_addr_data_port : bus.data_port_fg;
   assign lane_d = swap ? swap_bytes(bus_d) : bus_d;
   assign even_b = lane_d[7:0];
   assign odd_b  = lane_d[15:8];
   assign word_q = st_reg.mem[idx];
   // reads return the whole word; the host ignores the unused lane
   assign rbus   = swap ? swap_bytes(word_q) : word_q;

   // next state: latch, store, drive decisions, freed pins
   always_comb begin
      st_next = st_reg;
      // multiplexed: capture only while the strobe is high; non-multiplexed: capture the pins every cycle
      if (mux_mode && ale) begin
         st_next.addr = bus.shared_addr_data_port;
      end else if (!mux_mode) begin
         st_next.addr = bus.shared_addr_data_port;
      end
      // a long strobe repeats the store each edge with the same data, which
      // is cheaper than an edge detector on every strobe pin
      // an access needs the strobe low, else the bus holds address
      if (wr && hit && !(mux_mode && ale)) begin
         if (ev) begin
            st_next.mem[idx][7:0] = even_b;
         end
         if (od) begin
            st_next.mem[idx][15:8] = odd_b;
         end
      end
      // the one-cycle lag keeps the drive off the wires while the host
      // turns its own drivers around
      // drive one cycle after the read strobe is seen
      st_next.ad_out  = rbus;
      st_next.ad_oe_n = ~(mux_mode && rd && hit && !ale);
      // port f carries d7-d0 and port g d15-d8
      st_next.fg_out  = rbus;
      st_next.fg_oe_n = ~(!mux_mode && rd && hit);
      // disabled copy reads zero so idle port pins hold a known level
      // latched address out; zero while disabled
      st_next.lat_out = addr_out_en ? st_next.addr : 16'h0000;
      // freed pins pass through one register like every other output
      // pins the chosen roles leave unused go to other functions
      st_next.gla2      = bus_type == mbi_pkg::BT_WRL_RD_WRH ?
                          bus.control_input_two : 1'h0;
      st_next.spare_pd3 = bus_type != mbi_pkg::BT_WRL_RD_WRH ?
                          bus.aux_upper_write_pin : 1'h0;
      st_next.spare_pf  = (mux_mode && burst_mode) ?
                          4'h0 : bus.low_port_f_address_pins;
   end

   // the store lives in the state struct so one register holds all state;
   // clearing it on reset costs area but keeps reads after reset defined
   // single state register; the store clears on reset
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         st_reg <= mbi_pkg::DEV_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   // no output is combinational, so pins never glitch on decode changes
   // outputs straight from the state register
   assign bus.adp_d_out     = st_reg.ad_out;
   assign bus.adp_d_oe_n    = st_reg.ad_oe_n;
   assign bus.fg_d_out      = st_reg.fg_out;
   assign bus.fg_d_oe_n     = st_reg.fg_oe_n;
   assign latched_addr_out  = st_reg.lat_out;
   assign gla_in2           = st_reg.gla2;
   assign spare_pd3         = st_reg.spare_pd3;
   assign spare_pf          = st_reg.spare_pf;

endmodule
`default_nettype wire

/* mbi_pkg.sv */
// shared constants, types and reset values for the host bus port
package mbi_pkg;

   // internal word store of the device end
   localparam int MEM_WORDS = 16;

   // addr[15:5] window that selects the device's own resource
   localparam logic [10:0] RES_BASE = 11'h500;

   // host phase lengths in mclk cycles
   localparam logic [3:0] ALE_CYC  = 4'h2;
   localparam logic [3:0] STRB_CYC = 4'h4;

   // value seen on a shared wire that nobody drives
   localparam logic [15:0] BUS_IDLE = 16'hFFFF;

   // control pin roles, one-hot
   typedef enum logic [3:0] {
      BT_WR_RD_BHE  = 4'h1,   // write, read, high byte enable
      BT_WRL_RD_WRH = 4'h2,   // lower write, read, upper write on aux pin
      BT_RW_DS_SIZ  = 4'h4,   // read/write select, data strobe, size
      BT_RW_LDS_UDS = 4'h8    // read/write select, lower and upper data strobes
   } mbi_bus_type_t;

   // host sequencer states, one-hot
   typedef enum logic [2:0] {
      HS_IDLE = 3'h1,
      HS_ADDR = 3'h2,
      HS_STRB = 3'h4
   } mbi_host_state_t;

   // device end state
   typedef struct packed {
      logic [15:0]                  addr;      // latched address
      logic [MEM_WORDS-1:0][15:0]   mem;       // words as {odd, even}
      logic [15:0]                  ad_out;
      logic                         ad_oe_n;
      logic [15:0]                  fg_out;    // {port g, port f}
      logic                         fg_oe_n;
      logic [15:0]                  lat_out;
      logic                         gla2;
      logic                         spare_pd3;
      logic [3:0]                   spare_pf;
   } mbi_dev_st_t;

   // host end state
   typedef struct packed {
      mbi_host_state_t st;
      logic [3:0]      cnt;
      logic            wr;
      logic            word;
      logic [19:0]     addr;
      logic [15:0]     wdata;
      logic [15:0]     ad_out;
      logic            ad_oe_n;
      logic [15:0]     fg_out;
      logic            fg_oe_n;
      logic [3:0]      ctl;        // {pd3, c2, c1, c0}
      logic            ale;
      logic [3:0]      pf;
      logic [3:0]      ext;
      logic [15:0]     rdata;
      logic            done;
      logic            busy;
   } mbi_host_st_t;

   localparam mbi_dev_st_t DEV_RST = '{ad_oe_n: 1'h1, fg_oe_n: 1'h1, default: '0};
   localparam mbi_host_st_t HOST_RST = '{st: HS_IDLE, ad_oe_n: 1'h1, fg_oe_n: 1'h1,
                                         ctl: 4'hF, default: '0};

endpackage

/* mbi_bus_if.sv */
// pins between the host and the companion device
`timescale 1ns/100ps
`default_nettype none
interface mbi_bus_if;
   logic [15:0] adp_h_out;
   logic        adp_h_oe_n;
   logic [15:0] adp_d_out;
   logic        adp_d_oe_n;
   logic [15:0] shared_addr_data_port;
   logic [15:0] fg_h_out;
   logic        fg_h_oe_n;
   logic [15:0] fg_d_out;
   logic        fg_d_oe_n;
   logic [15:0] data_port_fg;           // {port g, port f}
   logic        control_input_zero;
   logic        control_input_one;
   logic        control_input_two;
   logic        aux_upper_write_pin;
   logic        aux_latch_strobe_pin;
   logic [3:0]  low_port_f_address_pins;

   // wire resolution, pulled high when released
   assign shared_addr_data_port = !adp_h_oe_n ? adp_h_out :
                                  !adp_d_oe_n ? adp_d_out : mbi_pkg::BUS_IDLE;
   assign data_port_fg = !fg_h_oe_n ? fg_h_out :
                         !fg_d_oe_n ? fg_d_out : mbi_pkg::BUS_IDLE;

   modport dev (
      input  shared_addr_data_port, data_port_fg,
      input  control_input_zero, control_input_one, control_input_two,
      input  aux_upper_write_pin, aux_latch_strobe_pin, low_port_f_address_pins,
      output adp_d_out, adp_d_oe_n, fg_d_out, fg_d_oe_n
   );
   modport host (
      input  shared_addr_data_port, data_port_fg,
      output control_input_zero, control_input_one, control_input_two,
      output aux_upper_write_pin, aux_latch_strobe_pin, low_port_f_address_pins,
      output adp_h_out, adp_h_oe_n, fg_h_out, fg_h_oe_n
   );
endinterface
`default_nettype wire

/* mbi_host.sv */
// host end: microcontroller external bus master
`timescale 1ns/100ps
`default_nettype none
module mbi_host (
   input  wire logic                   mclk,        // system clock
   input  wire logic                   rst_b,       // async reset, active low
   mbi_bus_if.host                     bus,         // bus pins
   input  wire logic                   mux_mode,    // 1: multiplexed bus
   input  wire logic                   burst_mode,  // 1: burst reads allowed
   input  wire mbi_pkg::mbi_bus_type_t bus_type,    // control pin roles
   input  wire logic                   req,         // start a transfer
   input  wire logic                   wr,          // 1: write
   input  wire logic                   word,        // 1: both bytes
   input  wire logic                   burst_next,  // reuse held upper address
   input  wire logic [19:0]            addr,        // byte address
   input  wire logic [15:0]            wdata,       // {odd, even}
   output logic [15:0]                 rdata,       // {odd, even}
   output logic                        done,        // transfer finished
   output logic                        busy,        // transfer running
   output logic [3:0]                  ext_addr_out // upper address to ports a/b/c
);

   mbi_pkg::mbi_host_st_t st_reg;
   mbi_pkg::mbi_host_st_t st_next;
   logic                  swap;
   logic [15:0]           bus_wd;
   logic [15:0]           bus_rd;

   // strobe pattern {pd3, c2, c1, c0} for an active access
   function automatic logic [3:0] enc_ctl(mbi_pkg::mbi_bus_type_t bt, logic w,
                                          logic wd, logic a0);
      logic ev;
      logic od;
      ev = wd | ~a0;
      od = wd | a0;
      case (bt)
         mbi_pkg::BT_WR_RD_BHE:  enc_ctl = {1'h1, ~od, w, ~w};
         mbi_pkg::BT_WRL_RD_WRH: enc_ctl = {~(w & od), 1'h1, w, ~(w & ev)};
         mbi_pkg::BT_RW_DS_SIZ:  enc_ctl = {1'h1, ~wd, 1'h0, ~w};
         mbi_pkg::BT_RW_LDS_UDS: enc_ctl = {1'h1, ~ev, ~od, ~w};
         default:                enc_ctl = 4'hF;
      endcase
   endfunction

   // lane exchange, used on both the write and the read path
   function automatic logic [15:0] swap_bytes(input logic [15:0] d);
      swap_bytes = {d[7:0], d[15:8]};
   endfunction

   // even byte rides the upper lane on select/strobe hosts
   assign swap   = bus_type == mbi_pkg::BT_RW_DS_SIZ || bus_type == mbi_pkg::BT_RW_LDS_UDS;
   assign bus_wd = swap ? swap_bytes(st_reg.wdata) : st_reg.wdata;
   assign bus_rd = mux_mode ? bus.shared_addr_data_port : bus.data_port_fg;

   // sequencer: address phase (skipped on a burst step), strobe phase, back to idle
   always_comb begin
      st_next = st_reg;
      st_next.done = 1'h0;
      case (st_reg.st)
         mbi_pkg::HS_IDLE: begin
            if (req) begin
               st_next.wr    = wr;
               st_next.word  = word;
               st_next.wdata = wdata;
               st_next.busy  = 1'h1;
               if (burst_next && mux_mode && burst_mode && !wr) begin
                  // upper address stays latched in the device
                  st_next.addr[3:1] = addr[3:1];
                  st_next.pf = {addr[3:1], 1'h0};
                  st_next.ctl = enc_ctl(bus_type, 1'h0, 1'h1, 1'h0);
                  st_next.cnt = mbi_pkg::STRB_CYC - 4'h1;
                  st_next.st  = mbi_pkg::HS_STRB;
               end else begin
                  st_next.addr    = addr;
                  st_next.ext     = addr[19:16];
                  st_next.ad_out  = addr[15:0];
                  st_next.ad_oe_n = 1'h0;
                  st_next.ale     = mux_mode;
                  st_next.pf      = {addr[3:1], 1'h0};
                  st_next.cnt     = mbi_pkg::ALE_CYC - 4'h1;
                  st_next.st      = mbi_pkg::HS_ADDR;
               end
            end
         end
         mbi_pkg::HS_ADDR: begin
            if (st_reg.cnt == 4'h0) begin
               st_next.ale = 1'h0;
               st_next.ctl = enc_ctl(bus_type, st_reg.wr, st_reg.word, st_reg.addr[0]);
               if (mux_mode) begin
                  // read: release so the device can answer
                  st_next.ad_oe_n = ~st_reg.wr;
                  st_next.ad_out  = bus_wd;
               end else begin
                  st_next.fg_out  = bus_wd;
                  st_next.fg_oe_n = ~st_reg.wr;
               end
               st_next.cnt = mbi_pkg::STRB_CYC - 4'h1;
               st_next.st  = mbi_pkg::HS_STRB;
            end else begin
               st_next.cnt = st_reg.cnt - 4'h1;
            end
         end
         mbi_pkg::HS_STRB: begin
            if (st_reg.cnt == 4'h0) begin
               st_next.ctl     = 4'hF;
               st_next.ad_oe_n = 1'h1;
               st_next.fg_oe_n = 1'h1;
               if (!st_reg.wr) begin
                  st_next.rdata = swap ? swap_bytes(bus_rd) : bus_rd;
               end
               st_next.done = 1'h1;
               st_next.busy = 1'h0;
               st_next.st   = mbi_pkg::HS_IDLE;
            end else begin
               st_next.cnt = st_reg.cnt - 4'h1;
            end
         end
         default: begin
            st_next = mbi_pkg::HOST_RST;
         end
      endcase
   end

   // single state register
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         st_reg <= mbi_pkg::HOST_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   // pins and user outputs straight from the state register
   assign bus.adp_h_out               = st_reg.ad_out;
   assign bus.adp_h_oe_n              = st_reg.ad_oe_n;
   assign bus.fg_h_out                = st_reg.fg_out;
   assign bus.fg_h_oe_n               = st_reg.fg_oe_n;
   assign bus.control_input_zero      = st_reg.ctl[0];
   assign bus.control_input_one       = st_reg.ctl[1];
   assign bus.control_input_two       = st_reg.ctl[2];
   assign bus.aux_upper_write_pin     = st_reg.ctl[3];
   assign bus.aux_latch_strobe_pin    = st_reg.ale;
   assign bus.low_port_f_address_pins = st_reg.pf;
   assign rdata                       = st_reg.rdata;
   assign done                        = st_reg.done;
   assign busy                        = st_reg.busy;
   assign ext_addr_out                = st_reg.ext;

endmodule
`default_nettype wire

/* mbi_bus_asserts.sv */
// concurrent checks on the pins between the host and the device ends
`timescale 1ns/100ps
`default_nettype none
module mbi_bus_asserts (
   input wire logic                   mclk,                    // system clock
   input wire logic                   rst_b,                   // async reset, active low
   input wire logic                   mux_mode,                // multiplexed bus
   input wire logic                   burst_mode,              // burst reads allowed
   input wire mbi_pkg::mbi_bus_type_t bus_type,                // control pin roles
   input wire logic                   addr_out_en,             // show latched address
   input wire logic                   adp_d_oe_n,              // device shared port enable
   input wire logic                   fg_d_oe_n,               // device data port enable
   input wire logic                   control_input_zero,      // control pin zero
   input wire logic                   control_input_one,       // control pin one
   input wire logic                   control_input_two,       // control pin two
   input wire logic                   aux_upper_write_pin,     // aux pin
   input wire logic                   aux_latch_strobe_pin,    // latch strobe
   input wire logic [3:0]             low_port_f_address_pins, // low port f
   input wire logic [15:0]            latched_addr_out,        // latched address
   input wire logic                   gla_in2,                 // logic array input
   input wire logic                   spare_pd3,               // freed aux pin
   input wire logic [3:0]             spare_pf                 // freed low port f
);
   logic rd_act;

   // read strobe as the configured pin roles define it
   always_comb begin
      if (bus_type == mbi_pkg::BT_WR_RD_BHE || bus_type == mbi_pkg::BT_WRL_RD_WRH) begin
         rd_act = !control_input_one;
      end else if (bus_type == mbi_pkg::BT_RW_DS_SIZ) begin
         rd_act = control_input_zero && !control_input_one;
      end else begin
         rd_act = control_input_zero && !(control_input_one && control_input_two);
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   // strobe seen active, then released
   sequence rd_end_s;
      rd_act ##1 !rd_act;
   endsequence

   adp_read_a: assert property (!adp_d_oe_n |-> $past(mux_mode && rd_act))
      else $error("shared port driven outside a read");
   fg_read_a: assert property (!fg_d_oe_n |-> $past(!mux_mode && rd_act))
      else $error("data ports driven outside a read");
   mux_fg_quiet_a: assert property (mux_mode |-> fg_d_oe_n)
      else $error("data ports driven in multiplexed mode");
   nonmux_adp_quiet_a: assert property (!mux_mode |-> adp_d_oe_n)
      else $error("shared port driven in non-multiplexed mode");
   drive_release_a: assert property (rd_end_s |=> adp_d_oe_n && fg_d_oe_n)
      else $error("drive kept after the read strobe ended");
   // several low cycles give margin for the one-cycle output lag
   addr_hold_a: assert property (
      (mux_mode && !burst_mode && addr_out_en && !aux_latch_strobe_pin) [*4]
      |-> $stable(latched_addr_out))
      else $error("latched address moved while strobe low");
   burst_hold_a: assert property (
      (mux_mode && burst_mode && addr_out_en && !aux_latch_strobe_pin) [*4]
      |-> $stable(latched_addr_out[15:4]))
      else $error("upper address moved during burst");
   gla_pass_a: assert property (bus_type == mbi_pkg::BT_WRL_RD_WRH
      |=> gla_in2 == $past(control_input_two))
      else $error("free control pin not passed to logic array");
   gla_zero_a: assert property (bus_type != mbi_pkg::BT_WRL_RD_WRH |=> !gla_in2)
      else $error("logic array input set while pin in use");
   pd3_spare_a: assert property (bus_type != mbi_pkg::BT_WRL_RD_WRH
      |=> spare_pd3 == $past(aux_upper_write_pin))
      else $error("unused aux pin not freed");
   pf_spare_a: assert property (!(mux_mode && burst_mode)
      |=> spare_pf == $past(low_port_f_address_pins))
      else $error("unused low port f not freed");
endmodule
`default_nettype wire

/* testbench.sv */
// testbench joining host and device ends through the bus interface
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic                   mclk, rst_b, mux_mode, burst_mode, addr_out_en, req, wr, word;
   logic                   burst_next, done, busy, gla_in2, spare_pd3, saw_c1_low;
   logic [19:0]            addr;
   logic [15:0]            wdata, rdata, latched_addr_out, seen_fg, exp_w;
   logic [15:0]            mem [16];
   logic [3:0]             ext_a, ext_match, spare_pf;
   mbi_pkg::mbi_bus_type_t bus_type;
   mbi_pkg::mbi_bus_type_t types [4];
   int                     miscompares, n_compared;

   mbi_bus_if bus ();
   mbi_host mbi_host_inst (.mclk, .rst_b, .bus, .mux_mode, .burst_mode, .bus_type, .req,
      .wr, .word, .burst_next, .addr, .wdata, .rdata, .done, .busy, .ext_addr_out(ext_a));
   mbi_device mbi_device_inst (.mclk, .rst_b, .bus, .mux_mode, .burst_mode, .bus_type,
      .addr_out_en, .ext_addr(ext_a), .ext_match, .latched_addr_out, .gla_in2, .spare_pd3,
      .spare_pf);
   mbi_bus_asserts chk (.mclk, .rst_b, .mux_mode, .burst_mode, .bus_type, .addr_out_en,
      .adp_d_oe_n(bus.adp_d_oe_n), .fg_d_oe_n(bus.fg_d_oe_n),
      .control_input_zero(bus.control_input_zero), .control_input_one(bus.control_input_one),
      .control_input_two(bus.control_input_two), .aux_upper_write_pin(bus.aux_upper_write_pin),
      .aux_latch_strobe_pin(bus.aux_latch_strobe_pin),
      .low_port_f_address_pins(bus.low_port_f_address_pins), .latched_addr_out, .gla_in2,
      .spare_pd3, .spare_pf);

   task automatic stop_test();
      $display("compared %0d, mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one host transfer; watches the wire for lane order and strobe roles
   task automatic xfer(input logic w, input logic wd, input logic bn, input logic [19:0] a,
                       input logic [15:0] d);
      int n;
      @(negedge mclk);
      req = 1'h1;
      {wr, word, burst_next, addr, wdata} = {w, wd, bn, a, d};
      @(negedge mclk);
      req = 1'h0;
      saw_c1_low = 1'h0;
      seen_fg = 16'h0000;
      n = 0;
      while (done !== 1'h1 && n < 30) begin
         if (bus.control_input_one === 1'h0) saw_c1_low = 1'h1;
         if (bus.fg_h_oe_n === 1'h0) seen_fg = bus.data_port_fg;
         @(negedge mclk);
         n++;
      end
      if (n == 30) begin
         miscompares++;
         $display("MISMATCH t=%0t transfer never finished", $time);
      end
   endtask

   task automatic rd_chk(input logic [19:0] a, input logic bn, input logic [15:0] exp);
      xfer(1'h0, 1'h1, bn, a, 16'h0000);
      check(rdata, exp);
   endtask

   // one bus type and mode: word, byte lanes, foreign upper address
   task automatic cfg(input int i);
      logic [19:0] a;
      logic        sw;
      a = 20'h3A000 + 20'(4 * i);
      sw = bus_type inside {mbi_pkg::BT_RW_DS_SIZ, mbi_pkg::BT_RW_LDS_UDS};
      exp_w = 16'hA050 + 16'h0101 * 16'(i);
      @(negedge mclk);
      check(gla_in2, bus_type == mbi_pkg::BT_WRL_RD_WRH);
      check(spare_pd3, bus_type != mbi_pkg::BT_WRL_RD_WRH);
      xfer(1'h1, 1'h1, 1'h0, a, exp_w);
      check(saw_c1_low, sw);
      // lane order on the wire differs between the two strobe families
      if (!mux_mode) check(seen_fg, sw ? {exp_w[7:0], exp_w[15:8]} : exp_w);
      rd_chk(a, 1'h0, exp_w);
      if (mux_mode) check(latched_addr_out, a[15:0]);
      xfer(1'h1, 1'h0, 1'h0, a + 20'h00001, 16'hC3C3);
      exp_w[15:8] = 8'hC3;
      rd_chk(a, 1'h0, exp_w);
      xfer(1'h1, 1'h0, 1'h0, a, 16'h3C3C);
      exp_w[7:0] = 8'h3C;
      rd_chk(a, 1'h0, exp_w);
      xfer(1'h1, 1'h1, 1'h0, a ^ 20'h60000, 16'h0F0F);
      rd_chk(a, 1'h0, exp_w);
      rd_chk(a ^ 20'h60000, 1'h0, 16'hFFFF);
      mem[2 * i] = exp_w;
   endtask

   initial begin
      mclk = 1'h0;
      forever #4 mclk = ~mclk;
   end

   // far beyond the several hundred cycles the sequence needs
   initial begin
      #(8 * 20000);
      miscompares++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      stop_test();
   end

   initial begin
      rst_b = 1'h0;
      {mux_mode, burst_mode, req, wr, word, burst_next} = '0;
      {addr, wdata} = '0;
      addr_out_en = 1'h1;
      ext_match = 4'h3;
      bus_type = mbi_pkg::BT_WR_RD_BHE;
      types = '{mbi_pkg::BT_WR_RD_BHE, mbi_pkg::BT_WRL_RD_WRH, mbi_pkg::BT_RW_DS_SIZ,
                mbi_pkg::BT_RW_LDS_UDS};
      foreach (mem[j]) mem[j] = 16'h0000;
      miscompares = 0;
      n_compared = 0;
      repeat (6) @(negedge mclk);
      rst_b = 1'h1;
      @(negedge mclk);
      check(bus.shared_addr_data_port, 16'hFFFF);
      check(bus.data_port_fg, 16'hFFFF);
      for (int i = 0; i < 8; i++) begin
         mux_mode = i[0];
         bus_type = types[i / 2];
         cfg(i);
      end
      // burst: upper address held, low word lines stepped
      mux_mode = 1'h1;
      burst_mode = 1'h1;
      bus_type = mbi_pkg::BT_WRL_RD_WRH;
      rd_chk(20'h3A000, 1'h0, mem[0]);
      for (int j = 1; j < 8; j++) begin
         rd_chk(20'h3A000 + 20'(2 * j), 1'h1, mem[j]);
      end
      addr_out_en = 1'h0;
      repeat (2) @(negedge mclk);
      check(latched_addr_out, 16'h0000);
      stop_test();
   end
endmodule
`default_nettype wire
